// File: common/fcn_cls_if.sv
`timescale 1ns/10ps
interface fcn_cls_if;
	logic [63:0]        value;
	logic               single_fmt;
	logic               sign;
	logic               is_zero;
	logic               is_den;
	logic               is_nor;
	logic               is_inf;
	logic               is_nan;
	logic               is_snan;
	logic signed [13:0] exp;
	logic [52:0]        sig;

	modport cls (input value, single_fmt, output sign, is_zero, is_den, is_nor,
		is_inf, is_nan, is_snan, exp, sig);
	modport user (output value, single_fmt, input sign, is_zero, is_den, is_nor,
		is_inf, is_nan, is_snan, exp, sig);
endinterface : fcn_cls_if

// File: common/fcn_pkg.sv
package fcn_pkg;
	localparam int EXP_W = 14;
	localparam int SIG_W = 56;

	localparam logic [2:0] OP_FINISH  = 3'h0;
	localparam logic [2:0] OP_ROUND_S = 3'h1;
	localparam logic [2:0] OP_LOAD_S  = 3'h2;
	localparam logic [2:0] OP_STORE_S = 3'h3;
	localparam logic [2:0] OP_PRENORM = 3'h4;

	localparam logic [1:0] RM_NEAR = 2'h0;
	localparam logic [1:0] RM_ZERO = 2'h1;
	localparam logic [1:0] RM_PINF = 2'h2;
	localparam logic [1:0] RM_MINF = 2'h3;

	localparam logic signed [13:0] EMIN_D = -14'sh3FE;
	localparam logic signed [13:0] EMAX_D = 14'sh3FF;
	localparam logic signed [13:0] EMIN_S = -14'sh7E;
	localparam logic signed [13:0] EMAX_S = 14'sh7F;
	localparam logic signed [13:0] BIAS_D = 14'sh3FF;
	localparam logic signed [13:0] BIAS_S = 14'sh7F;

	localparam logic [10:0] EF_MAX_D = 11'h7FF;
	localparam logic [10:0] EF_MAX_S = 11'h0FF;
	localparam logic [63:0] QBIT_D   = 64'h0008_0000_0000_0000;
	localparam logic [63:0] QNAN_D   = 64'h7FF8_0000_0000_0000;
endpackage : fcn_pkg

// File: core/fcn_classify.sv
`timescale 1ns/10ps
module fcn_classify (
	fcn_cls_if.cls c
);
	// A single operand sits in the low word; its fraction is left-aligned to 52 bits.
	wire [10:0] ef     = c.single_fmt ? {3'h0, c.value[30:23]} : c.value[62:52];
	wire [51:0] fr     = c.single_fmt ? {c.value[22:0], 29'h0} : c.value[51:0];
	wire [10:0] ef_max = c.single_fmt ? fcn_pkg::EF_MAX_S : fcn_pkg::EF_MAX_D;
	wire        e_zero = (ef == 11'h000);
	wire        e_full = (ef == ef_max);
	wire        f_zero = (fr == 52'h0);
	wire signed [13:0] bias = c.single_fmt ? fcn_pkg::BIAS_S : fcn_pkg::BIAS_D;
	wire signed [13:0] emin = c.single_fmt ? fcn_pkg::EMIN_S : fcn_pkg::EMIN_D;

	assign c.sign    = c.single_fmt ? c.value[31] : c.value[63];
	assign c.is_nor  = !e_zero && !e_full; // [RULE1]
	assign c.is_zero = e_zero && f_zero; // [RULE2]
	assign c.is_den  = e_zero && !f_zero; // [RULE3]
	assign c.is_inf  = e_full && f_zero; // [RULE4]
	assign c.is_nan  = e_full && !f_zero; // [RULE5]
	assign c.is_snan = c.is_nan && !fr[51]; // [RULE5]
	assign c.exp     = c.is_den ? emin : $signed({3'h0, ef}) - bias; // [RULE3]
	assign c.sig     = {c.is_nor, fr}; // [RULE1] [RULE3]
endmodule : fcn_classify

// File: core/fcn_unit.sv
// Functional notes
// RULE1: Biased exponent 1..254 single or 1..2046 double is normal, lead bit one.
// RULE2: Zero exponent and zero fraction is zero, either sign.
// RULE3: Zero exponent, nonzero fraction is denormal: lead bit zero, minimum exponent.
// RULE4: Maximum exponent with zero fraction is infinity.
// RULE5: Maximum exponent, nonzero fraction is NaN; top fraction bit one means quiet.
// RULE6: NaN result takes first, else second, else third NaN operand, else generated.
// RULE7: Generated quiet NaN: sign zero, exponent all ones, only top fraction bit set.
// RULE8: Normalize by left shifts, exponent minus one each; round bit fills zero.
// RULE9: Exponent unbounded while normalizing; below format minimum marks tiny; sign kept.
// RULE10: Denormalize by right shifts up to minimum; lost bits mean underflow.
// RULE11: Denormal operands of multiply or divide are prenormalized first.
// RULE12: Arithmetic runs in double; single only via load, round and store.
// RULE13: Single load widens to double and detects no exceptions.
// RULE14: Round-to-single rounds, range checks, flags, and writes back double format.
// RULE15: Single store narrows, denormalizing when needed, detecting no exceptions.
// RULE16: Mode 00 nearest, 01 toward zero, 10 plus infinity, 11 minus infinity.
// RULE17: Rounding alters the value only when it is not representable.
// RULE18: Exactly representable values come out truncated in every mode.
// RULE19: Nearest picks the closer neighbour; ties go to even.
// RULE20: Zero mode picks smaller magnitude; plus picks larger; minus picks smaller.
// RULE21: Infinities pass exactly and raise nothing unless the operation is invalid.
// RULE22: Quiet NaNs pass silently; signaling NaN operands raise invalid.
`timescale 1ns/10ps
module fcn_unit (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        start_in,
	input  wire logic [2:0]  op_in,
	input  wire logic [1:0]  round_mode_in,
	input  wire logic        invalid_op_enable_in,
	input  wire logic [63:0] first_source_operand_in,
	input  wire logic [63:0] second_source_operand_in,
	input  wire logic [63:0] third_source_operand_in,
	input  wire logic [31:0] single_word_in,
	input  wire logic        nan_due_in,
	input  wire logic        int_inf_in,
	input  wire logic        int_sign_in,
	input  wire logic [13:0] int_exp_in,
	input  wire logic [55:0] int_sig_in,
	output logic             busy_out,
	output logic             done_out,
	output logic             write_en_out,
	output logic [63:0]      target_operand_out,
	output logic [13:0]      opnd_exp_out,
	output logic [55:0]      opnd_sig_out,
	output logic             tiny_out,
	output logic             underflow_out,
	output logic             overflow_out,
	output logic             inexact_out,
	output logic             invalid_out
);
	typedef enum logic [1:0] {ST_IDLE, ST_NORM, ST_DENORM, ST_ROUND} fcn_state_t;

	fcn_state_t         state_reg;
	logic [2:0]         op_reg;
	logic [1:0]         mode_reg;
	logic               fmt_s_reg;
	logic               sign_reg;
	logic signed [13:0] exp_reg;
	logic [55:0]        sig_reg;
	logic               tiny_reg;
	logic               unf_reg;
	logic               ovf_reg;
	logic               inx_reg;
	logic               inv_reg;
	logic               done_reg;
	logic               wr_reg;
	logic [63:0]        target_reg;
	logic [13:0]        oexp_reg;
	logic [55:0]        osig_reg;

	// Operands 0..2 are the double sources, entry 3 is the single word from memory.
	fcn_cls_if cls_if[4] ();
	wire [63:0] opnd_w [4];
	assign opnd_w[0] = first_source_operand_in;
	assign opnd_w[1] = second_source_operand_in;
	assign opnd_w[2] = third_source_operand_in;
	assign opnd_w[3] = {32'h0, single_word_in};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cls
			assign cls_if[gi].value      = opnd_w[gi];
			assign cls_if[gi].single_fmt = (gi == 3);
			fcn_classify u_cls (
				.c (cls_if[gi])
			);
		end
	endgenerate

	// NaN selection for a NaN result.
	wire any_snan = cls_if[0].is_snan | cls_if[1].is_snan | cls_if[2].is_snan; // [RULE22]
	wire none_nan = !(cls_if[0].is_nan | cls_if[1].is_nan | cls_if[2].is_nan);
	wire [63:0] nan_pick = cls_if[0].is_nan ? (opnd_w[0] | fcn_pkg::QBIT_D) : // [RULE6]
		cls_if[1].is_nan ? (opnd_w[1] | fcn_pkg::QBIT_D) :
		cls_if[2].is_nan ? (opnd_w[2] | fcn_pkg::QBIT_D) :
		fcn_pkg::QNAN_D; // [RULE7]
	wire fin_inv = any_snan | none_nan;

	// Source selection for the finish and conversion ops.
	wire is_fin  = (op_in == fcn_pkg::OP_FINISH);
	wire is_load = (op_in == fcn_pkg::OP_LOAD_S);
	wire to_sgl  = (op_in == fcn_pkg::OP_ROUND_S) || (op_in == fcn_pkg::OP_STORE_S); // [RULE12]
	wire src_sign = is_fin ? int_sign_in : is_load ? cls_if[3].sign : cls_if[0].sign;
	wire signed [13:0] src_exp = is_fin ? $signed(int_exp_in) :
		is_load ? cls_if[3].exp : cls_if[0].exp;
	wire [55:0] src_sig = is_fin ? int_sig_in :
		is_load ? {cls_if[3].sig, 3'h0} : {cls_if[0].sig, 3'h0};
	wire src_nan  = is_load ? cls_if[3].is_nan : cls_if[0].is_nan;
	wire src_inf  = is_load ? cls_if[3].is_inf : cls_if[0].is_inf;
	wire src_zero = is_load ? cls_if[3].is_zero : cls_if[0].is_zero;
	wire src_spec = src_nan | src_inf | src_zero;
	wire rnd_snan = (op_in == fcn_pkg::OP_ROUND_S) && cls_if[0].is_snan; // [RULE22]
	wire [63:0] a_q = opnd_w[0] | fcn_pkg::QBIT_D;

	// Specials bypass the shifter: infinities and zeros are exact, NaNs go quiet on round to single only.
	wire [63:0] spec_w =
		is_load ? (src_zero ? {src_sign, 63'h0} : // [RULE13]
			{src_sign, fcn_pkg::EF_MAX_D, cls_if[3].sig[51:0]}) :
		(op_in == fcn_pkg::OP_STORE_S) ? (src_zero ? {32'h0, src_sign, 31'h0} : // [RULE15]
			{32'h0, src_sign, fcn_pkg::EF_MAX_S[7:0], opnd_w[0][51:29]}) :
		src_nan ? {a_q[63:29], 29'h0} : opnd_w[0]; // [RULE21]

	// Rounding datapath on the normalized or denormalized intermediate.
	wire signed [13:0] emin_t = fmt_s_reg ? fcn_pkg::EMIN_S : fcn_pkg::EMIN_D;
	wire signed [13:0] emax_t = fmt_s_reg ? fcn_pkg::EMAX_S : fcn_pkg::EMAX_D;
	wire [52:0] kept  = fmt_s_reg ? {29'h0, sig_reg[55:32]} : sig_reg[55:3];
	wire        g_bit = fmt_s_reg ? sig_reg[31] : sig_reg[2];
	wire        s_bit = fmt_s_reg ? |sig_reg[30:0] : |sig_reg[1:0];
	wire        inexact_w = g_bit | s_bit; // [RULE17]
	wire        up_near   = g_bit & (s_bit | kept[0]); // [RULE19]
	wire        up_dir    = inexact_w & (((mode_reg == fcn_pkg::RM_PINF) & !sign_reg) | // [RULE20]
		((mode_reg == fcn_pkg::RM_MINF) & sign_reg));
	wire        round_up  = (mode_reg == fcn_pkg::RM_NEAR) ? up_near : up_dir; // [RULE16]
	wire [53:0] sum       = {1'b0, kept} + {53'h0, round_up}; // [RULE18]
	wire        carry     = fmt_s_reg ? sum[24] : sum[53];
	wire        lead      = carry | (fmt_s_reg ? sum[23] : sum[52]);
	wire signed [13:0] exp_r = exp_reg + $signed({13'h0, carry});
	wire        ovf_w     = lead && (exp_r > emax_t);
	wire [13:0] bexp_d    = exp_r + fcn_pkg::BIAS_D;
	wire [13:0] bexp_s    = exp_r + fcn_pkg::BIAS_S;
	wire [51:0] frac_d    = carry ? 52'h0 : sum[51:0];
	wire [22:0] frac_s    = carry ? 23'h0 : sum[22:0];
	wire [63:0] pack_d = ovf_w ? {sign_reg, fcn_pkg::EF_MAX_D, 52'h0} :
		!lead ? {sign_reg, 11'h000, fmt_s_reg ? {29'h0, sum[22:0]} : frac_d} :
		fmt_s_reg ? {sign_reg, bexp_d[10:0], frac_s, 29'h0} : // [RULE14]
		{sign_reg, bexp_d[10:0], frac_d};
	wire [31:0] pack_s = ovf_w ? {sign_reg, fcn_pkg::EF_MAX_S[7:0], 23'h0} :
		{sign_reg, lead ? bexp_s[7:0] : 8'h00, frac_s}; // [RULE15]
	// A single denormal cannot be kept in double format as is: it goes round again as double.
	wire rewiden  = fmt_s_reg && (op_reg == fcn_pkg::OP_ROUND_S) && !lead && (sum[23:0] != 24'h0);
	wire quiet_op = (op_reg == fcn_pkg::OP_LOAD_S) || (op_reg == fcn_pkg::OP_STORE_S); // [RULE13]

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg  <= ST_IDLE;
			op_reg     <= fcn_pkg::OP_FINISH;
			mode_reg   <= fcn_pkg::RM_NEAR;
			fmt_s_reg  <= 1'b0;
			sign_reg   <= 1'b0;
			exp_reg    <= 14'sh0;
			sig_reg    <= 56'h0;
			tiny_reg   <= 1'b0;
			unf_reg    <= 1'b0;
			ovf_reg    <= 1'b0;
			inx_reg    <= 1'b0;
			inv_reg    <= 1'b0;
			done_reg   <= 1'b0;
			wr_reg     <= 1'b0;
			target_reg <= 64'h0;
			oexp_reg   <= 14'h0;
			osig_reg   <= 56'h0;
		end else begin
			done_reg <= 1'b0;
			case (state_reg)
				ST_IDLE: if (start_in) begin
					op_reg    <= op_in;
					mode_reg  <= (op_in == fcn_pkg::OP_STORE_S) ? fcn_pkg::RM_ZERO : round_mode_in;
					fmt_s_reg <= to_sgl;
					sign_reg  <= src_sign;
					exp_reg   <= src_exp;
					sig_reg   <= src_sig;
					tiny_reg  <= 1'b0;
					unf_reg   <= 1'b0;
					ovf_reg   <= 1'b0;
					inx_reg   <= 1'b0;
					inv_reg   <= 1'b0;
					wr_reg    <= 1'b1;
					if (is_fin && nan_due_in) begin
						target_reg <= nan_pick; // [RULE6]
						inv_reg    <= fin_inv; // [RULE22]
						wr_reg     <= !(fin_inv && invalid_op_enable_in);
						done_reg   <= 1'b1;
					end else if (is_fin && int_inf_in) begin
						target_reg <= {int_sign_in, fcn_pkg::EF_MAX_D, 52'h0}; // [RULE21]
						done_reg   <= 1'b1;
					end else if (is_fin && int_sig_in[55:1] == 55'h0) begin
						target_reg <= {int_sign_in, 63'h0};
						inx_reg    <= int_sig_in[0];
						done_reg   <= 1'b1;
					end else if (op_in == fcn_pkg::OP_PRENORM && !cls_if[0].is_den) begin
						oexp_reg <= cls_if[0].exp;
						osig_reg <= {cls_if[0].sig, 3'h0};
						done_reg <= 1'b1;
					end else if (op_in > fcn_pkg::OP_PRENORM) begin
						wr_reg   <= 1'b0;
						done_reg <= 1'b1;
					end else if (!is_fin && op_in != fcn_pkg::OP_PRENORM && src_spec) begin
						target_reg <= spec_w;
						inv_reg    <= rnd_snan; // [RULE22]
						wr_reg     <= !(rnd_snan && invalid_op_enable_in);
						done_reg   <= 1'b1;
					end else begin
						state_reg <= ST_NORM; // [RULE11]
					end
				end
				ST_NORM: begin
					if (!sig_reg[55]) begin
						sig_reg <= {sig_reg[54:1], 1'b0, sig_reg[0]}; // [RULE8]
						exp_reg <= exp_reg - 14'sh1; // [RULE8]
					end else if (op_reg == fcn_pkg::OP_PRENORM) begin
						oexp_reg  <= exp_reg; // [RULE11]
						osig_reg  <= sig_reg;
						done_reg  <= 1'b1;
						state_reg <= ST_IDLE;
					end else if (exp_reg < emin_t) begin
						tiny_reg  <= !quiet_op; // [RULE9]
						state_reg <= ST_DENORM;
					end else begin
						state_reg <= ST_ROUND;
					end
				end
				ST_DENORM: begin
					if (exp_reg < emin_t) begin
						sig_reg <= {1'b0, sig_reg[55:2], sig_reg[1] | sig_reg[0]}; // [RULE10]
						exp_reg <= exp_reg + 14'sh1;
					end else begin
						state_reg <= ST_ROUND;
					end
				end
				ST_ROUND: begin
					inx_reg <= inx_reg | ((inexact_w | ovf_w) & !quiet_op);
					ovf_reg <= ovf_reg | (ovf_w & !quiet_op);
					unf_reg <= unf_reg | (tiny_reg & inexact_w & !quiet_op); // [RULE10]
					if (rewiden) begin
						sig_reg   <= {sum[23:0], 32'h0}; // [RULE14]
						exp_reg   <= fcn_pkg::EMIN_S;
						fmt_s_reg <= 1'b0;
						state_reg <= ST_NORM;
					end else begin
						target_reg <= (op_reg == fcn_pkg::OP_STORE_S) ? {32'h0, pack_s} : pack_d;
						done_reg   <= 1'b1;
						state_reg  <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign busy_out           = (state_reg != ST_IDLE);
	assign done_out           = done_reg;
	assign write_en_out       = wr_reg;
	assign target_operand_out = target_reg;
	assign opnd_exp_out       = oexp_reg;
	assign opnd_sig_out       = osig_reg;
	assign tiny_out           = tiny_reg;
	assign underflow_out      = unf_reg;
	assign overflow_out       = ovf_reg;
	assign inexact_out        = inx_reg;
	assign invalid_out        = inv_reg;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	wire idle_go = (state_reg == ST_IDLE) && start_in;
	sequence s_nan_req;
		idle_go && is_fin && nan_due_in;
	endsequence
	sequence s_nan_done;
		done_out && invalid_out == $past(fin_inv);
	endsequence

	property p_nan_first;
		s_nan_req and cls_if[0].is_nan |=> s_nan_done ##0 target_operand_out == $past(a_q);
	endproperty
	a_nan_first: assert property (p_nan_first) else $error("first NaN not chosen"); // [RULE6]

	property p_gen_qnan;
		s_nan_req and none_nan |=> s_nan_done ##0 target_operand_out == 64'h7FF8_0000_0000_0000;
	endproperty
	a_gen_qnan: assert property (p_gen_qnan) else $error("bad generated quiet NaN"); // [RULE7]

	property p_norm_step;
		state_reg == ST_NORM && !sig_reg[55] |=> exp_reg == $past(exp_reg) - 14'sh1
			&& sig_reg[55:2] == $past(sig_reg[54:1]) && !sig_reg[1];
	endproperty
	a_norm_step: assert property (p_norm_step) else $error("normalize step wrong"); // [RULE8]

	property p_tiny_mark;
		state_reg == ST_NORM && sig_reg[55] && exp_reg < emin_t && !quiet_op
			&& op_reg != fcn_pkg::OP_PRENORM |=> tiny_out && state_reg == ST_DENORM;
	endproperty
	a_tiny_mark: assert property (p_tiny_mark) else $error("tiny not marked"); // [RULE9]

	property p_sign_kept;
		state_reg inside {ST_NORM, ST_DENORM} |=> $stable(sign_reg);
	endproperty
	a_sign_kept: assert property (p_sign_kept) else $error("sign changed in shifter"); // [RULE9]

	property p_denorm_step;
		state_reg == ST_DENORM && exp_reg < emin_t |=> exp_reg == $past(exp_reg) + 14'sh1
			&& !sig_reg[55];
	endproperty
	a_denorm_step: assert property (p_denorm_step) else $error("denormalize step wrong"); // [RULE10]

	property p_exact_trunc;
		state_reg == ST_ROUND && !g_bit && !s_bit |-> sum[52:0] == kept;
	endproperty
	a_exact_trunc: assert property (p_exact_trunc) else $error("exact value altered"); // [RULE18]

	property p_tie_even;
		state_reg == ST_ROUND && mode_reg == 2'h0 && g_bit && !s_bit |-> round_up == kept[0];
	endproperty
	a_tie_even: assert property (p_tie_even) else $error("tie not to even"); // [RULE19]

	property p_toward_zero;
		state_reg == ST_ROUND && mode_reg == 2'h1 |-> !round_up;
	endproperty
	a_toward_zero: assert property (p_toward_zero) else $error("toward zero rounded up"); // [RULE20]

	property p_quiet_ops;
		done_out && quiet_op |-> !(inexact_out || underflow_out || overflow_out || invalid_out);
	endproperty
	a_quiet_ops: assert property (p_quiet_ops) else $error("load or store raised a flag"); // [RULE13]

	property p_suppress;
		done_out && invalid_out && $past(invalid_op_enable_in, 1) && $past(idle_go) |-> !write_en_out;
	endproperty
	a_suppress: assert property (p_suppress) else $error("enabled invalid still writes"); // [RULE22]
endmodule : fcn_unit

// File: test/fcn_rf_model.sv
`timescale 1ns/10ps
// Stand-in for the register file on the far side of the unit. It counts writes and keeps the last
// result written, so the bench can tell that a suppressed result leaves the target alone.
module fcn_rf_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        done_in,
	input  wire logic        write_en_in,
	input  wire logic [63:0] target_in,
	output logic [63:0]      fp_register_out,
	output logic [15:0]      wr_count_out
);
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fp_register_out <= 64'h0;
			wr_count_out    <= 16'h0;
		end else if (done_in && write_en_in) begin
			fp_register_out <= target_in;
			wr_count_out    <= wr_count_out + 16'h1;
		end
	end
endmodule : fcn_rf_model

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
	localparam logic [63:0] SN = 64'h7FF0_0000_0000_0001;
	localparam logic [63:0] QN = 64'hFFF8_0000_0000_0ABC;
	localparam logic [63:0] NR = 64'h3FF0_0000_0000_0000;
	logic        clk = 1'b0, rst = 1'b1, start = 1'b0, ve = 1'b0;
	logic        nan_due = 1'b0, i_inf = 1'b0, i_sign = 1'b0;
	logic [2:0]  op = 3'h0;
	logic [1:0]  rm = 2'h0;
	logic [63:0] a = 64'h0, b = 64'h0, c = 64'h0;
	logic [31:0] sw = 32'h0;
	logic [13:0] i_exp = 14'h0;
	logic [55:0] i_sig = 56'h0;
	logic        busy, done, we;
	logic [63:0] tgt, rf_val;
	logic [13:0] o_exp;
	logic [55:0] o_sig;
	logic [4:0]  fl;
	logic [15:0] wr_cnt;
	int          failures = 0, num_checks = 0, cyc = 0, ewr = 0;

	fcn_unit dut (
		.clk_in(clk), .rst_in(rst), .start_in(start), .op_in(op), .round_mode_in(rm),
		.invalid_op_enable_in(ve), .first_source_operand_in(a),
		.second_source_operand_in(b), .third_source_operand_in(c), .single_word_in(sw),
		.nan_due_in(nan_due), .int_inf_in(i_inf), .int_sign_in(i_sign), .int_exp_in(i_exp),
		.int_sig_in(i_sig), .busy_out(busy), .done_out(done), .write_en_out(we),
		.target_operand_out(tgt), .opnd_exp_out(o_exp), .opnd_sig_out(o_sig),
		.tiny_out(fl[4]), .underflow_out(fl[3]), .overflow_out(fl[2]), .inexact_out(fl[1]),
		.invalid_out(fl[0])
	);
	fcn_rf_model rf (
		.clk_in(clk), .rst_in(rst), .done_in(done), .write_en_in(we), .target_in(tgt),
		.fp_register_out(rf_val), .wr_count_out(wr_cnt)
	);

	always #10 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] want);
		num_checks++;
		if (seen !== want) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk

	function automatic logic rnd_up(logic [1:0] m, logic s, logic l, logic g, logic r);
		case (m)
			fcn_pkg::RM_NEAR: return g & (r | l);
			fcn_pkg::RM_ZERO: return 1'b0;
			fcn_pkg::RM_PINF: return ~s & (g | r);
			default: return s & (g | r);
		endcase
	endfunction : rnd_up

	function automatic logic [63:0] dbl(logic s, int e, logic [55:0] g, logic [1:0] m);
		logic [52:0] f;
		f = {1'b0, g[54:3]} + 53'(rnd_up(m, s, g[3], g[2], |g[1:0]));
		return {s, 11'(e + 1023 + int'(f[52])), f[51:0]};
	endfunction : dbl

	function automatic logic [63:0] sgl(logic [63:0] d, logic [1:0] m);
		logic [23:0] f;
		f = {1'b0, d[51:29]} + 24'(rnd_up(m, d[63], d[29], d[28], |d[27:0]));
		return {d[63], 11'(d[62:52] + f[23]), f[22:0], 29'h0};
	endfunction : sgl

	function automatic logic [63:0] widen(logic [31:0] w);
		int p;
		if (w[30:23] == 8'hFF) return {w[31], 11'h7FF, w[22:0], 29'h0};
		if (w[30:23] != 8'h00) return {w[31], 11'(w[30:23] + 896), w[22:0], 29'h0};
		if (w[22:0] == 23'h0) return {w[31], 63'h0};
		p = 22;
		while (!w[p]) p--;
		return {w[31], 11'(p + 874), 52'({w[22:0], 29'h0} << (23 - p))};
	endfunction : widen

	// Called right after a rising edge; the operands set by the caller stay put until the
	// next operation, which covers the whole time the unit may still be sampling them.
	task automatic go(input logic [2:0] o);
		int n;
		op <= o;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 3000);
		// A hung operation counts as a mismatch here; the run still closes in print_verdict.
		if (n >= 3000) chk("done", 64'(done), 64'h1);
		@(negedge clk);
	endtask : go

	task automatic res(input logic [63:0] v, input logic [4:0] f, input logic w);
		ewr += int'(w);
		if (w) chk("result", tgt, v);
		if (w) chk("register", rf_val, v);
		chk("flags", 64'(fl), 64'(f));
		chk("write", 64'(we), 64'(w));
		chk("writes", 64'(wr_cnt), 64'(ewr));
	endtask : res

	task automatic nanc(input logic [63:0] x, y, z, r, input logic iv);
		@(posedge clk);
		a <= x;
		b <= y;
		c <= z;
		nan_due <= 1'b1;
		go(fcn_pkg::OP_FINISH);
		res(r, {4'h0, iv}, ~(iv & ve));
	endtask : nanc

	task automatic fin(input logic s, input int e, input logic [55:0] g, input logic [1:0] m,
			input logic [63:0] r, input logic [4:0] f);
		@(posedge clk);
		nan_due <= 1'b0;
		i_sign <= s;
		i_exp <= 14'(e);
		i_sig <= g;
		rm <= m;
		go(fcn_pkg::OP_FINISH);
		res(r, f, 1'b1);
	endtask : fin

	task automatic ld(input logic [31:0] w);
		@(posedge clk);
		sw <= w;
		go(fcn_pkg::OP_LOAD_S);
		res(widen(w), 5'h0, 1'b1);
	endtask : ld

	initial begin
		logic [54:0] cs [4] = '{55'h4, 55'hC, '1, 55'h28};
		logic [31:0] lw [6] = '{32'h3F80_0001, 32'h8000_0000, 32'h0000_0005, 32'h8040_0000,
			32'hFF80_0000, 32'h7FC0_0001};
		logic        s;
		int          e, n;
		logic [55:0] g;
		logic [1:0]  m;
		logic [63:0] d;
		void'($urandom(69));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("idle", {62'h0, busy, done}, 64'h0);
		chk("reset target", tgt, 64'h0);
		nanc(SN, QN, NR, SN | fcn_pkg::QBIT_D, 1'b1);
		nanc(NR, QN, SN, QN, 1'b1);
		nanc(NR, NR, QN, QN, 1'b0);
		nanc(NR, NR, NR, fcn_pkg::QNAN_D, 1'b1);
		@(posedge clk);
		ve <= 1'b1;
		nanc(NR, NR, NR, fcn_pkg::QNAN_D, 1'b1);
		@(posedge clk);
		ve <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			g = {1'b1, cs[k % 4]};
			m = 2'(k / 4);
			fin(k[0], 5, g, m, dbl(k[0], 5, g, m), {3'h0, |g[2:0], 1'h0});
		end
		repeat (40) begin
			s = 1'($urandom);
			e = int'($urandom_range(2000)) - 1000;
			m = 2'($urandom);
			g = {1'b1, 23'($urandom), $urandom};
			fin(s, e, g, m, dbl(s, e, g, m), {3'h0, |g[2:0], 1'h0});
			n = 1 + int'($urandom_range(7));
			// Bit 0 is sticky and does not travel with the shift, so it must start clear too.
			g = g & ~56'h1FF;
			fin(s, e + n, g >> n, m, dbl(s, e, g, m), 5'h0);
		end
		g = {1'b1, 23'($urandom), $urandom} & ~56'h1F;
		fin(1'b0, -1024, g, m, {12'h0, 52'(g[55:3] >> 2)}, 5'h10);
		g[3] = 1'b1;
		fin(1'b1, -1024, g, fcn_pkg::RM_ZERO, {12'h800, 52'(g[55:3] >> 2)}, 5'h1A);
		fin(1'b0, 1024, {1'b1, 55'h0}, fcn_pkg::RM_NEAR, 64'h7FF0_0000_0000_0000, 5'h06);
		fin(1'b1, 0, 56'h0, fcn_pkg::RM_NEAR, 64'h8000_0000_0000_0000, 5'h0);
		@(posedge clk);
		i_inf <= 1'b1;
		go(fcn_pkg::OP_FINISH);
		res(64'hFFF0_0000_0000_0000, 5'h0, 1'b1);
		@(posedge clk);
		i_inf <= 1'b0;
		foreach (lw[i]) ld(lw[i]);
		repeat (8) begin
			d[31:0] = $urandom;
			d[30:29] = 2'h1;
			ld(d[31:0]);
		end
		for (int k = 0; k < 20; k++) begin
			d = (k < 4) ? 64'hBFF0_0000_3000_0000 : {$urandom, $urandom};
			d[62:52] = 11'(923 + int'($urandom_range(200)));
			m = 2'(k);
			@(posedge clk);
			a <= d;
			rm <= m;
			go(fcn_pkg::OP_ROUND_S);
			res(sgl(d, m), {3'h0, |d[28:0], 1'h0}, 1'b1);
		end
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			a <= (k == 2) ? 64'hFFF0_0000_0000_0000 : SN;
			ve <= k[0];
			go(fcn_pkg::OP_ROUND_S);
			d = (k == 2) ? 64'hFFF0_0000_0000_0000 : (SN | fcn_pkg::QBIT_D) & ~64'h1FFF_FFFF;
			res(d, {4'h0, k < 2}, k != 1);
		end
		// A single denormal result has to be brought back to double format as a normal value.
		d = {$urandom, $urandom} & ~64'h3FFF_FFFF;
		d[62:52] = 11'h380;
		d[29] = 1'b1;
		@(posedge clk);
		a <= d;
		rm <= fcn_pkg::RM_ZERO;
		go(fcn_pkg::OP_ROUND_S);
		res({d[63:30], 30'h0}, 5'h1A, 1'b1);
		for (int k = 0; k < 9; k++) begin
			d = {$urandom, $urandom} & ~64'h3FFF_FFFF;
			d[62:52] = 11'(896 + ((k == 0) ? 0 : int'($urandom_range(254, 1))));
			@(posedge clk);
			a <= d;
			go(fcn_pkg::OP_STORE_S);
			if (k == 0) begin
				res({32'h0, d[63], 8'h00, 23'({1'b1, d[51:29]} >> 1)}, 5'h0, 1'b1);
			end else begin
				res({32'h0, d[63], 8'(d[62:52] - 896), d[51:29]}, 5'h0, 1'b1);
			end
		end
		for (int k = 5; k < 8; k++) begin
			@(posedge clk);
			go(3'(k));
			res(64'h0, 5'h0, 1'b0);
		end
		repeat (6) begin
			n = int'($urandom_range(51));
			d = {1'($urandom), 11'h0, 52'h1 << n};
			@(posedge clk);
			a <= d;
			go(fcn_pkg::OP_PRENORM);
			chk("opnd_exp", 64'(o_exp), {50'h0, 14'(n - 1074)});
			chk("opnd_sig", 64'(o_sig), 64'h0080_0000_0000_0000);
		end
		print_verdict();
	end
endmodule : tb
